// File: dv/rbs_board.sv
// Board side: reset switch and mode straps.
`timescale 1ns/1ns
`default_nettype none
module rbs_board (
  input wire logic clk, holdRst, reset_indication_out_n,
  input wire logic [2:0] cfg,
  output logic ext_reset_in_n, bus_active_select, bus_config_sel1, bus_config_sel0
);
  logic [2:0] straps = 3'h0;
  // Straps hold only around reset, then flip each cycle so a late resample shows.
  always @(negedge clk) straps <= holdRst || !reset_indication_out_n ? cfg : ~straps;
  assign {bus_active_select, bus_config_sel1, bus_config_sel0} = straps;
  assign ext_reset_in_n = !holdRst;
endmodule
`default_nettype wire

// File: dv/rbs_checker.sv
// Assertions on the reset, mode and segment pin outputs.
`timescale 1ns/1ns
`default_nettype none
module rbs_checker #(parameter bit PRESCALED = 1'b1) (
  input wire logic clk, rstn, ext_reset_in_n, sw_reset, wdt_reset, end_of_init_instruction,
  input wire logic reset_indication_out_n, device_reset, ext_bus, cfg_reserved, cpu_clk_en,
  input wire logic [1:0] seg_dir, seg_addr, seg_port_oe, seg_port_out,
  input wire rbs_pkg::rbs_mode_t bus_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_ext_hold: assert property (!ext_reset_in_n [*8] ##1 !ext_reset_in_n |->
    ##[1:3] !reset_indication_out_n) else $error("ind high in reset");
  chk_eoi_only: assert property ($rose(reset_indication_out_n) |->
    $past(end_of_init_instruction) || $past(end_of_init_instruction, 2)
    || $past(end_of_init_instruction, 3)) else $error("early release");
  chk_soft_ind: assert property ((sw_reset || wdt_reset) && reset_indication_out_n |->
    ##[1:3] !reset_indication_out_n) else $error("soft reset unseen");
  chk_mode_flags: assert property ($stable(bus_mode) |-> ext_bus == (bus_mode < 3'h4) &&
    cfg_reserved == (bus_mode == rbs_pkg::RBS_MODE_RESERVED)) else $error("mode flags");
  chk_mode_frozen: assert property (reset_indication_out_n &&
    $past(reset_indication_out_n) |-> $stable(bus_mode)) else $error("mode moved");
  chk_pin_dir: assert property (!ext_bus && $stable({ext_bus, seg_dir}) && $past(rstn) |->
    seg_port_oe == seg_dir) else $error("direction");
  chk_pin_bus: assert property (ext_bus && !device_reset && $past(rstn) &&
    $stable({ext_bus, device_reset, seg_addr}) |-> seg_port_oe == 2'h3 &&
    seg_port_out == seg_addr) else $error("segment lines");
  chk_clk_rate: assert property ($past(rstn) |-> cpu_clk_en ==
    (PRESCALED ? !$past(cpu_clk_en) : 1'b1)) else $error("clock rate");
  cov_release: cover property ($rose(reset_indication_out_n));
  cov_watchdog: cover property (wdt_reset && reset_indication_out_n);
  cov_bus_pins: cover property (ext_bus && seg_port_oe == 2'h3);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Testbench: boots each strap code, soft resets, a short reset pulse, segment pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, holdRst = 1'b1;
  logic sw_reset = 1'b0, wdt_reset = 1'b0, end_of_init_instruction = 1'b0;
  logic [2:0] cfg = 3'h0;
  logic [1:0] drv = 2'h0, seg_dir = 2'h0, seg_data = 2'h0, seg_addr = 2'h0;
  logic [1:0] seg_port_in, seg_port_out, seg_port_oe, seg_port_value;
  logic ext_reset_in_n, bus_active_select, bus_config_sel1, bus_config_sel0;
  logic reset_indication_out_n, device_reset, ext_bus, cfg_reserved, cpu_clk_en;
  rbs_pkg::rbs_mode_t bus_mode;
  int failures = 0, checks_done = 0;
  always #10 clk = ~clk;
  assign seg_port_in = (seg_port_oe & seg_port_out) | (~seg_port_oe & drv);
  rbs_reset_busconfig #(.PRESCALED(1'b1)) DUT (.*);
  rbs_board board (.*);
  task results();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(logic [2:0] got, logic [2:0] exp);
    checks_done++;
    if (got !== exp) failures++;
    if (got !== exp) $display("unexpected at %0t: %0h not %0h", $time, got, exp);
  endtask
  task ticks(int n);
    repeat (n) @(negedge clk);
  endtask
  task eoi();
    end_of_init_instruction = 1'b1;
    ticks(1);
    end_of_init_instruction = 1'b0;
  endtask
  task run_up();
    eoi();
    for (int i = 0; reset_indication_out_n !== 1'b1; i++) begin
      if (i == 9) cmp(3'h0, 3'h1);
      if (i == 9) results();
      ticks(1);
    end
  endtask
  task t_boot(logic [2:0] code);
    cfg = code;
    holdRst = 1'b1;
    ticks(12);
    cmp(reset_indication_out_n, 1'b0);
    cmp(device_reset, 1'b1);
    eoi();
    holdRst = 1'b0;
    ticks(12);
    cmp(reset_indication_out_n, 1'b0);
    run_up();
    cmp(device_reset, 1'b0);
    cmp(bus_mode, code > 3'h4 ? 3'h7 : code);
    cmp({ext_bus, cfg_reserved}, {code < 3'h4, code > 3'h4});
  endtask
  task t_soft(logic wd);
    {wdt_reset, sw_reset} = {wd, !wd};
    ticks(1);
    {wdt_reset, sw_reset} = 2'h0;
    ticks(9);
    cmp(reset_indication_out_n, 1'b0);
    run_up();
  endtask
  task t_seg(logic bus);
    logic [1:0] oe, out;
    for (int d = 0; d < 4; d++) begin
      {seg_dir, seg_data, seg_addr, drv} = 8'(d * 8'h4b);
      ticks(6);
      oe = bus ? 2'h3 : seg_dir;
      out = bus ? seg_addr : seg_data;
      cmp(seg_port_oe, oe);
      cmp(seg_port_out & oe, out & oe);
      cmp(seg_port_value, oe & out | ~oe & drv);
    end
  endtask
  initial begin
    ticks(16);
    rstn = 1'b1;
    for (int k = 0; k < 8; k++) begin
      t_boot(3'(k));
      t_seg(k < 4);
    end
    t_soft(1'b0);
    t_soft(1'b1);
    holdRst = 1'b1;
    ticks(3);
    holdRst = 1'b0;
    ticks(10);
    cmp(reset_indication_out_n, 1'b1);
    results();
  end
endmodule
bind rbs_reset_busconfig rbs_checker #(.PRESCALED(PRESCALED)) chk (.*);
`default_nettype wire

// File: rtl/rbs_pkg.sv
// Package with constants and types for the reset, bus configuration and segment port block.
package rbs_pkg;

  // ----------------------------------------------------------------
  // Bus configuration select codes {busActive, sel1, sel0}
  // ----------------------------------------------------------------
  localparam logic [2:0] RBS_CFG_DEMUX8 = 3'h0;
  localparam logic [2:0] RBS_CFG_MUX8 = 3'h1;
  localparam logic [2:0] RBS_CFG_MUX16 = 3'h2;
  localparam logic [2:0] RBS_CFG_DEMUX16 = 3'h3;
  localparam logic [2:0] RBS_CFG_SINGLE = 3'h4;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int RBS_SEG_W = 2;
  localparam int RBS_SEG_LSB = 0;
  localparam int RBS_SEG_MSB = 1;
  localparam int RBS_SYNC_W = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  // Least external reset low time, in ns (chosen, not documented).
  localparam int RBS_RST_MIN_NS = 100;
  localparam int RBS_CLK_NS = 20;
  localparam int RBS_RST_MIN_CYC = (RBS_RST_MIN_NS + RBS_CLK_NS - 1) / RBS_CLK_NS;
  localparam logic [3:0] RBS_RST_CNT_MAX = 4'(RBS_RST_MIN_CYC);
  localparam logic [2:0] RBS_SYNC_RST = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RBS_RUN = 2'h0,
    RBS_HOLD = 2'h1,
    RBS_INIT = 2'h3
  } rbs_state_t;

  typedef enum logic [2:0] {
    RBS_MODE_DEMUX8 = 3'h0,
    RBS_MODE_MUX8 = 3'h1,
    RBS_MODE_MUX16 = 3'h2,
    RBS_MODE_DEMUX16 = 3'h3,
    RBS_MODE_SINGLE = 3'h4,
    RBS_MODE_RESERVED = 3'h7
  } rbs_mode_t;

endpackage

// File: rtl/rbs_reset_busconfig.sv
// Reset sequencing, bus configuration latch, clock derivation and segment port top.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Long enough low reset input resets device.
// - Indication low on hardware, software, watchdog reset.
// - Indication stays low until end of init.
// - Configuration pins sampled and latched during hardware reset.
// - Decode latched pins into bus, single or reserved mode.
// - Each segment pin has own direction bit.
// - Input pin driver is high impedance.
// - Segment address lines drive pins in bus mode outside device reset.
// - Prescaled variant halves oscillator clock.
// - Direct variant uses oscillator clock unchanged.
module rbs_reset_busconfig #(
  parameter bit PRESCALED = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_reset_in_n,
  input wire logic sw_reset,
  input wire logic wdt_reset,
  input wire logic end_of_init_instruction,
  input wire logic bus_active_select,
  input wire logic bus_config_sel1,
  input wire logic bus_config_sel0,
  input wire logic [1:0] seg_dir,
  input wire logic [1:0] seg_data,
  input wire logic [1:0] seg_addr,
  input wire logic [1:0] seg_port_in,
  output logic [1:0] seg_port_out,
  output logic [1:0] seg_port_oe,
  output logic [1:0] seg_port_value,
  output logic reset_indication_out_n,
  output logic device_reset,
  output rbs_pkg::rbs_mode_t bus_mode,
  output logic ext_bus,
  output logic cfg_reserved,
  output logic cpu_clk_en
);

  typedef struct packed {
    rbs_pkg::rbs_state_t state;
    logic [2:0] r1;
    logic [2:0] r2;
    logic [2:0] r3;
    logic [2:0] ba;
    logic rstLevel;
    logic [3:0] lowCnt;
    logic [2:0] cfg;
    rbs_pkg::rbs_mode_t mode;
    logic indN;
    logic devRst;
    logic div;
  } rbs_state_all_t;

  rbs_state_all_t st;
  rbs_state_all_t next_st;
  rbs_seg_if seg ();

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.r1 = {ext_reset_in_n, bus_config_sel1, bus_config_sel0};
    next_st.r1[2] = ext_reset_in_n;
    next_st.r2 = st.r1;
    next_st.r3 = st.r2;
    next_st.ba = {st.ba[1:0], bus_active_select};
    if (st.r2[2] == st.r3[2]) begin
      next_st.rstLevel = st.r3[2];
    end
    next_st.devRst = 1'b0;
    if (!st.rstLevel) begin
      if (st.lowCnt != rbs_pkg::RBS_RST_CNT_MAX) begin
        next_st.lowCnt = st.lowCnt + 4'h1;
      end
    end else begin
      next_st.lowCnt = 4'h0;
    end
    unique case (st.state)
      rbs_pkg::RBS_RUN: begin
        if (!st.rstLevel && st.lowCnt == rbs_pkg::RBS_RST_CNT_MAX) begin
          next_st.state = rbs_pkg::RBS_HOLD;
        end else if (sw_reset || wdt_reset) begin
          next_st.state = rbs_pkg::RBS_INIT;
          next_st.devRst = 1'b1;
        end
      end
      rbs_pkg::RBS_HOLD: begin
        next_st.devRst = 1'b1;
        // A strap pattern counts only once the second and third stages agree.
        if ({st.ba[1], st.r2[1:0]} == {st.ba[2], st.r3[1:0]}) begin
          next_st.cfg = {st.ba[2], st.r3[1:0]};
        end
        if (st.rstLevel) begin
          next_st.state = rbs_pkg::RBS_INIT;
        end
      end
      rbs_pkg::RBS_INIT: begin
        if (!st.rstLevel && st.lowCnt == rbs_pkg::RBS_RST_CNT_MAX) begin
          next_st.state = rbs_pkg::RBS_HOLD;
        end else if (end_of_init_instruction) begin
          next_st.state = rbs_pkg::RBS_RUN;
        end
      end
      default: begin
        next_st.state = rbs_pkg::RBS_HOLD;
      end
    endcase
    // Indication low in hold and init phases, high only in run.
    next_st.indN = (next_st.state == rbs_pkg::RBS_RUN);
    unique case (st.cfg)
      rbs_pkg::RBS_CFG_DEMUX8: next_st.mode = rbs_pkg::RBS_MODE_DEMUX8;
      rbs_pkg::RBS_CFG_MUX8: next_st.mode = rbs_pkg::RBS_MODE_MUX8;
      rbs_pkg::RBS_CFG_MUX16: next_st.mode = rbs_pkg::RBS_MODE_MUX16;
      rbs_pkg::RBS_CFG_DEMUX16: next_st.mode = rbs_pkg::RBS_MODE_DEMUX16;
      rbs_pkg::RBS_CFG_SINGLE: next_st.mode = rbs_pkg::RBS_MODE_SINGLE;
      default: next_st.mode = rbs_pkg::RBS_MODE_RESERVED;
    endcase
    next_st.div = PRESCALED ? ~st.div : 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.state <= rbs_pkg::RBS_HOLD;
      st.r1 <= rbs_pkg::RBS_SYNC_RST;
      st.r2 <= rbs_pkg::RBS_SYNC_RST;
      st.r3 <= rbs_pkg::RBS_SYNC_RST;
      st.ba <= rbs_pkg::RBS_SYNC_RST;
      st.rstLevel <= 1'b1;
      st.lowCnt <= 4'h0;
      st.cfg <= rbs_pkg::RBS_CFG_SINGLE;
      st.mode <= rbs_pkg::RBS_MODE_SINGLE;
      st.indN <= 1'b0;
      st.devRst <= 1'b1;
      st.div <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Segment port
  // ----------------------------------------------------------------
  assign seg.dir = seg_dir;
  assign seg.portData = seg_data;
  assign seg.segAddr = seg_addr;
  assign seg.segEnable = (st.mode <= rbs_pkg::RBS_MODE_DEMUX16) && !st.devRst;

  rbs_seg_port u_seg (
    .clk(clk),
    .rstn(rstn),
    .seg(seg.port),
    .seg_port_in(seg_port_in),
    .seg_port_out(seg_port_out),
    .seg_port_oe(seg_port_oe)
  );

  assign seg_port_value = seg.pinIn;
  assign reset_indication_out_n = st.indN;
  assign device_reset = st.devRst;
  assign bus_mode = st.mode;
  assign ext_bus = st.mode <= rbs_pkg::RBS_MODE_DEMUX16;
  assign cfg_reserved = st.mode == rbs_pkg::RBS_MODE_RESERVED;
  assign cpu_clk_en = st.div;

endmodule
`default_nettype wire

// File: rtl/rbs_seg_if.sv
// Interface carrying segment port controls between top and pin module.
`timescale 1ns/1ns
`default_nettype none
interface rbs_seg_if;
  logic [1:0] dir;
  logic [1:0] portData;
  logic [1:0] segAddr;
  logic segEnable;
  logic [1:0] pinIn;
  modport ctrl (output dir, output portData, output segAddr, output segEnable, input pinIn);
  modport port (input dir, input portData, input segAddr, input segEnable, output pinIn);
endinterface
`default_nettype wire

// File: rtl/rbs_seg_port.sv
// Two-pin segment port with per-pin direction and segment address output.
`timescale 1ns/1ns
`default_nettype none
module rbs_seg_port (
  input wire logic clk,
  input wire logic rstn,
  rbs_seg_if.port seg,
  input wire logic [1:0] seg_port_in,
  output logic [1:0] seg_port_out,
  output logic [1:0] seg_port_oe
);

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] val;
  } rbs_port_state_t;

  rbs_port_state_t st;
  rbs_port_state_t next_st;

  // ----------------------------------------------------------------
  // Per pin driver and input synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = seg_port_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < rbs_pkg::RBS_SEG_W; i++) begin
      // Pin 0 carries the low segment line, pin 1 the high one.
      next_st.out[i] = seg.segEnable ? seg.segAddr[i] : seg.portData[i];
      next_st.oe[i] = seg.segEnable | seg.dir[i];
      if (st.s2[i] == st.s3[i]) begin
        next_st.val[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign seg_port_out = st.out;
  assign seg_port_oe = st.oe;
  assign seg.pinIn = st.val;

endmodule
`default_nettype wire
